// ### design/aics_core.sv
// Purpose: Channel configuration commands, status answers and result scaling for eight inputs.
// Assumes: Command words and measurements come from logic on clk; power_lost comes from a pin.
// Notes: A measurement arrives in the 15-bit plus sign scale with separate range error flags.
module aics_core
    import aics_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        cmd_wr,
    input  wire logic [15:0] channel_command,
    input  wire logic [15:0] range_code_command,
    input  wire logic        power_lost,
    input  wire logic        meas_strobe,
    input  wire logic [2:0]  meas_chan,
    input  wire logic [15:0] meas_value,
    input  wire logic        meas_under,
    input  wire logic        meas_over,
    output logic      [15:0] command_response,
    output logic      [15:0] response_word_one,
    output logic      [15:0] response_word_two,
    output logic      [7:0]  channel_active,
    output logic             result_valid,
    output logic      [2:0]  result_chan,
    output logic      [15:0] result_15,
    output logic      [15:0] result_13,
    output logic      [15:0] result_12
);

    aics_mode_type cfg_mode [AICS_NUM_CH];
    logic [6:0]    cfg_code [AICS_NUM_CH];
    logic          pwr_meta;
    logic          pwr_lost_s;
    logic [7:0]    act_now;
    logic          is_cfg;
    logic          is_read;
    logic [15:0]   cfg_off;
    logic [2:0]    cfg_idx;
    logic          cfg_chan_ok;
    aics_mode_type cfg_kind;
    logic          cfg_illegal;
    logic [15:0]   rd_off;
    logic [3:0]    rd_x;
    logic [3:0]    rd_y;
    logic          rd_ok;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    function automatic aics_mode_type classify(input logic [15:0] code);
        aics_mode_type m;
        m = AICS_UNCONF;
        if (code[15:7] == 9'h000)
        begin
            if (code[6:0] >= AICS_UNI_LO && code[6:0] <= AICS_UNI_HI)
                m = AICS_UNIPOLAR;
            else if (code[6:0] >= AICS_BIP_LO && code[6:0] <= AICS_BIP_HI)
                m = AICS_BIPOLAR;
            else if (code[6:0] >= AICS_RTD_LO && code[6:0] <= AICS_RTD_HI)
                m = AICS_RTD;
            else if (code[6:0] >= AICS_OHM_LO && code[6:0] <= AICS_OHM_HI)
                m = AICS_OHM;
        end
        return m;
    endfunction
    function automatic logic [15:0] scale(input logic [15:0] v, input logic [3:0] sh, input logic [15:0] zero);
        return zero + 16'($signed(v) >>> sh);
    endfunction
    function automatic logic is_paired(input aics_mode_type m);
        return (m == AICS_BIPOLAR) || (m == AICS_RTD) || (m == AICS_OHM);
    endfunction

    // Power loss is a pin level, so it passes two flip-flops first.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pwr_meta   <= 1'b0;
            pwr_lost_s <= 1'b0;
        end
        else
        begin
            pwr_meta   <= power_lost;
            pwr_lost_s <= pwr_meta;
        end
    end

    always_comb
        for (int i = 0; i < AICS_NUM_CH; i++)
            act_now[i] = (cfg_mode[i] != AICS_UNCONF) && !(is_paired(cfg_mode[i]) && !i[0]);

    assign is_cfg      = channel_command >= AICS_CMD_CFG_BASE && channel_command <= AICS_CMD_CFG_LAST;
    assign is_read     = channel_command >= AICS_CMD_READ_BASE && channel_command <= AICS_CMD_READ_LAST;
    assign cfg_off     = channel_command - AICS_CMD_CFG_BASE;
    assign cfg_idx     = 3'(cfg_off - 16'h0001);
    assign cfg_chan_ok = cfg_off >= 16'h0001 && cfg_off <= 16'h0008;
    assign cfg_kind    = classify(range_code_command);
    assign cfg_illegal = !cfg_chan_ok || cfg_kind == AICS_UNCONF
                         || (cfg_kind == AICS_UNIPOLAR && is_paired(cfg_mode[cfg_idx]));
    assign rd_off      = channel_command - AICS_CMD_READ_BASE;
    assign rd_x        = 4'(rd_off % 16'h000a);
    assign rd_y        = 4'(rd_off / 16'h000a);
    assign rd_ok       = rd_x >= 4'h1 && rd_x <= 4'h8 && rd_y >= 4'h1 && rd_y <= 4'h8;

    // Channel configuration; a pair-mode code always writes both members.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            for (int i = 0; i < AICS_NUM_CH; i++)
            begin
                cfg_mode[i] <= AICS_UNCONF;
                cfg_code[i] <= 7'h00;
            end
        else if (pwr_lost_s)
            for (int i = 0; i < AICS_NUM_CH; i++)
            begin
                cfg_mode[i] <= AICS_UNCONF;
                cfg_code[i] <= 7'h00;
            end
        else if (cmd_wr && is_cfg && !cfg_illegal)
        begin
            if (is_paired(cfg_kind))
            begin
                cfg_mode[{cfg_idx[2:1], 1'b0}] <= cfg_kind;
                cfg_mode[{cfg_idx[2:1], 1'b1}] <= cfg_kind;
                cfg_code[{cfg_idx[2:1], 1'b0}] <= range_code_command[6:0];
                cfg_code[{cfg_idx[2:1], 1'b1}] <= range_code_command[6:0];
            end
            else
            begin
                cfg_mode[cfg_idx] <= cfg_kind;
                cfg_code[cfg_idx] <= range_code_command[6:0];
            end
        end
    end

    // Status answers, one cycle after each command write with a nonzero channel_command while pwr_lost_s is low.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            command_response  <= AICS_RESET_WORD;
            response_word_one <= AICS_RESET_WORD;
            response_word_two <= AICS_RESET_WORD;
        end
        else if (pwr_lost_s)
        begin
            command_response  <= AICS_RESET_WORD;
            response_word_one <= AICS_RESET_WORD;
            response_word_two <= AICS_RESET_WORD;
        end
        else if (cmd_wr && channel_command != 16'h0000)
        begin
            command_response  <= AICS_RESET_WORD;
            response_word_one <= AICS_RESET_WORD;
            response_word_two <= AICS_RESET_WORD;
            if (is_cfg)
            begin
                command_response[AICS_RESP_ILLEGAL] <= cfg_illegal;
                command_response[AICS_RESP_DONE]    <= !cfg_illegal;
            end
            else if (is_read && rd_ok)
            begin
                command_response[AICS_RESP_DONE] <= 1'b1;
                response_word_one <= {9'h000, cfg_code[3'(rd_x - 4'h1)]};
                response_word_two <= {9'h000, cfg_code[3'(rd_y - 4'h1)]};
            end
            else
                command_response[AICS_RESP_ILLEGAL] <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            channel_active <= 8'h00;
        else
            channel_active <= act_now;
    end

    // Result scaling into the three formats.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            result_valid <= 1'b0;
            result_chan  <= 3'h0;
            result_15    <= AICS_RESET_WORD;
            result_13    <= AICS_RESET_WORD;
            result_12    <= AICS_RESET_WORD;
        end
        else
        begin
            result_valid <= meas_strobe;
            if (meas_strobe)
            begin
                result_chan <= meas_chan;
                if (!act_now[meas_chan])
                begin
                    result_15 <= AICS_RESET_WORD;
                    result_13 <= AICS_RESET_WORD;
                    result_12 <= AICS_RESET_WORD;
                end
                else if (meas_under)
                begin
                    result_15 <= AICS_UNDER_15;
                    result_13 <= AICS_RESET_WORD;
                    result_12 <= AICS_RESET_WORD;
                end
                else if (meas_over)
                begin
                    result_15 <= AICS_OVER_15;
                    result_13 <= AICS_OVER_13;
                    result_12 <= AICS_OVER_12;
                end
                else
                begin
                    result_15 <= meas_value;
                    result_13 <= scale(meas_value, AICS_SHIFT_13, AICS_ZERO_13);
                    result_12 <= scale(meas_value, AICS_SHIFT_12, AICS_ZERO_12);
                end
            end
        end
    end

    property p_zero_map;
        meas_strobe && act_now[meas_chan] && !meas_under && !meas_over && meas_value == 16'h0000
        |=> result_13 == 16'h1000 && result_12 == 16'h0800 && result_15 == 16'h0000;
    endproperty
    a_zero_map: assert property (p_zero_map) else $error("zero does not map to mid codes");
    property p_rated_map;
        meas_strobe && act_now[meas_chan] && !meas_under && !meas_over && meas_value == 16'h8300
        |=> result_13 == 16'h0060 && result_12 == 16'h0030;
    endproperty
    a_rated_map: assert property (p_rated_map) else $error("negative rated point misscaled");
    property p_full_map;
        meas_strobe && act_now[meas_chan] && !meas_under && !meas_over && meas_value == 16'h7d00
        |=> result_13 == 16'h1fa0 && result_12 == 16'h0fd0;
    endproperty
    a_full_map: assert property (p_full_map) else $error("positive rated point misscaled");
    property p_under;
        meas_strobe && act_now[meas_chan] && meas_under |=> result_valid && result_15 == 16'h8001;
    endproperty
    a_under: assert property (p_under) else $error("underflow code wrong");
    property p_over;
        meas_strobe && act_now[meas_chan] && !meas_under && meas_over
        |=> result_15 == 16'h7fff && result_13 == 16'h1fff && result_12 == 16'h0fff;
    endproperty
    a_over: assert property (p_over) else $error("overflow codes wrong");
    property p_odd_zero;
        meas_strobe && !act_now[meas_chan] |=> result_15 == 16'h0000 && result_13 == 16'h0000;
    endproperty
    a_odd_zero: assert property (p_odd_zero) else $error("inactive channel data not zero");
    property p_high_chan;
        cmd_wr && !pwr_lost_s && channel_command > 16'h01fc && channel_command <= 16'h0257
        |=> command_response[0] && !command_response[1];
    endproperty
    a_high_chan: assert property (p_high_chan) else $error("channel above 8 not flagged");
    property p_cfg_words;
        cmd_wr && is_cfg |=> response_word_one == 16'h0000 && response_word_two == 16'h0000;
    endproperty
    a_cfg_words: assert property (p_cfg_words) else $error("config answer words not zero");
    // The pair index is taken from the command cycle, since later commands change cfg_idx.
    property p_pair_both;
        cmd_wr && is_cfg && !cfg_illegal && !pwr_lost_s && is_paired(cfg_kind) ##1 !pwr_lost_s
        |=> channel_active[{$past(cfg_idx[2:1], 2), 1'b1}] && !channel_active[{$past(cfg_idx[2:1], 2), 1'b0}];
    endproperty
    a_pair_both: assert property (p_pair_both) else $error("pair not configured as a unit");
    property p_reject_keep;
        cmd_wr && is_cfg && cfg_illegal && !pwr_lost_s |=> act_now == $past(act_now);
    endproperty
    a_reject_keep: assert property (p_reject_keep) else $error("rejected command changed config");
    property p_power_clear;
        pwr_lost_s |=> ##1 channel_active == 8'h00;
    endproperty
    a_power_clear: assert property (p_power_clear) else $error("power loss kept configuration");

endmodule

// ### design/aics_pkg.sv
// Purpose: Shared constants and types for the analog input command and scaling block.
// Assumes: One module clock; command words arrive from logic on the same clock.
// Notes: Command and code values are decimal figures written in hex.
package aics_pkg;

    localparam int          AICS_NUM_CH        = 8;
    localparam logic [15:0] AICS_CMD_CFG_BASE  = 16'h01f4;
    localparam logic [15:0] AICS_CMD_CFG_LAST  = 16'h0257;
    localparam logic [15:0] AICS_CMD_READ_BASE = 16'h0190;
    localparam logic [15:0] AICS_CMD_READ_LAST = 16'h01f3;
    localparam logic [6:0]  AICS_UNI_LO        = 7'h01;
    localparam logic [6:0]  AICS_UNI_HI        = 7'h1c;
    localparam logic [6:0]  AICS_BIP_LO        = 7'h21;
    localparam logic [6:0]  AICS_BIP_HI        = 7'h24;
    localparam logic [6:0]  AICS_RTD_LO        = 7'h40;
    localparam logic [6:0]  AICS_RTD_HI        = 7'h5f;
    localparam logic [6:0]  AICS_OHM_LO        = 7'h60;
    localparam logic [6:0]  AICS_OHM_HI        = 7'h74;
    localparam int          AICS_RESP_ILLEGAL  = 0;
    localparam int          AICS_RESP_DONE     = 1;
    localparam logic [15:0] AICS_UNDER_15      = 16'h8001;
    localparam logic [15:0] AICS_OVER_15       = 16'h7fff;
    localparam logic [15:0] AICS_OVER_13       = 16'h1fff;
    localparam logic [15:0] AICS_OVER_12       = 16'h0fff;
    localparam logic [15:0] AICS_ZERO_13       = 16'h1000;
    localparam logic [15:0] AICS_ZERO_12       = 16'h0800;
    localparam logic [3:0]  AICS_SHIFT_13      = 4'h3;
    localparam logic [3:0]  AICS_SHIFT_12      = 4'h4;
    localparam logic [15:0] AICS_RESET_WORD    = 16'h0000;

    typedef enum logic [2:0] {
        AICS_UNCONF   = 3'b000,
        AICS_UNIPOLAR = 3'b001,
        AICS_BIPOLAR  = 3'b010,
        AICS_RTD      = 3'b011,
        AICS_OHM      = 3'b100
    } aics_mode_type;

endpackage

// ### test/aics_host_model.sv
// Purpose: Host controller stand-in that writes the two host command registers.
// Assumes: Command words change after the falling edge and are taken at the next rising edge.
// Notes: Released command words show the inverse of the last value, never a stale copy.
module aics_host_model
    import aics_pkg::*;
(
    input  wire logic        clk,
    output logic             cmd_wr,
    output logic      [15:0] channel_command,
    output logic      [15:0] range_code_command
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd_wr = 1'b0;
        channel_command = 16'h0000;
        range_code_command = 16'h0000;
    end

    // Both words are binary; the strobe is held high across back-to-back sends.
    task automatic send(input logic [15:0] cmd, input logic [15:0] code);
        @(negedge clk);
        cmd_wr = 1'b1;
        channel_command = cmd;
        range_code_command = code;
    endtask

    task automatic release_bus();
        @(negedge clk);
        cmd_wr = 1'b0;
        channel_command = ~channel_command;
        range_code_command = ~range_code_command;
    endtask
endmodule

// ### test/tb_top.sv
// Purpose: Self-checking bench for the analog input command and scaling block.
// Assumes: 50 MHz clock; inputs change on the falling edge.
// Notes: Drivers queue expected results; a monitor pops and compares them as results appear.
module tb_top
    import aics_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rstn;
    logic        cmd_wr;
    logic [15:0] channel_command;
    logic [15:0] range_code_command;
    logic        power_lost;
    logic        meas_strobe;
    logic [2:0]  meas_chan;
    logic [15:0] meas_value;
    logic        meas_under;
    logic        meas_over;
    logic [15:0] command_response;
    logic [15:0] response_word_one;
    logic [15:0] response_word_two;
    logic [7:0]  channel_active;
    logic        result_valid;
    logic [2:0]  result_chan;
    logic [15:0] result_15;
    logic [15:0] result_13;
    logic [15:0] result_12;
    logic        cmd_seen = 1'b0;
    logic [6:0]  cfg [8];
    logic [48:0] cmd_q [$];
    logic [50:0] meas_q [$];
    int          num_errors;
    int          total_checks;
    int          seed;
    int          codes [7] = '{34, 35, 36, 64, 95, 96, 116};
    int          temps [6] = '{-32000, 0, 32000, 32766, -5, 1};

    aics_host_model u_aics_host_model (.clk(clk), .cmd_wr(cmd_wr), .channel_command(channel_command),
        .range_code_command(range_code_command));

    aics_core u_aics_core (.clk(clk), .rstn(rstn), .cmd_wr(cmd_wr), .channel_command(channel_command),
        .range_code_command(range_code_command), .power_lost(power_lost), .meas_strobe(meas_strobe),
        .meas_chan(meas_chan), .meas_value(meas_value), .meas_under(meas_under), .meas_over(meas_over),
        .command_response(command_response), .response_word_one(response_word_one),
        .response_word_two(response_word_two), .channel_active(channel_active),
        .result_valid(result_valid), .result_chan(result_chan), .result_15(result_15),
        .result_13(result_13), .result_12(result_12));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h got %h", what, exp, got);
        end
    endtask

    task automatic cmp_act(input logic [7:0] exp);
        total_checks++;
        if (channel_active !== exp)
        begin
            num_errors++;
            $display("[FAIL] channel_active expected %h got %h", exp, channel_active);
        end
    endtask

    // An even channel index holding a paired code is the hidden member of its pair.
    function automatic logic [7:0] exp_active();
        logic [7:0] a;
        for (int i = 0; i < 8; i++)
            a[i] = (cfg[i] != 7'h00) && !(i % 2 == 0 && cfg[i] >= AICS_BIP_LO);
        return a;
    endfunction

    // Kind 1 reads channels a (X) and b (Y); kind 0 configures channel a with code b.
    task automatic do_cmd(input logic rd, input int a, input int b);
        logic ok;
        int   p;
        if (rd)
        begin
            ok = a >= 1 && a <= 8 && b >= 1 && b <= 8;
            cmd_q.push_back(ok ? {1'b0, 16'h0002, 9'h0, cfg[a-1], 9'h0, cfg[b-1]} : {1'b1, 16'h0001, 32'h0});
            u_aics_host_model.send(16'(400 + 10 * b + a), 16'h0000);
        end
        else
        begin
            ok = a >= 1 && a <= 8 && ((b >= 1 && b <= 28 && cfg[a-1] < 7'd33) || (b >= 33 && b <= 36)
                 || (b >= 64 && b <= 116));
            p = (a - 1) / 2 * 2;
            if (ok && b >= 33)
            begin
                cfg[p] = 7'(b);
                cfg[p+1] = 7'(b);
            end
            else if (ok)
                cfg[a-1] = 7'(b);
            cmd_q.push_back({!ok, ok ? 16'h0002 : 16'h0001, 32'h0});
            u_aics_host_model.send(16'(500 + a), 16'(b));
        end
    endtask

    task automatic do_meas(input int ch, input logic signed [15:0] v, input logic un, input logic ov);
        logic [7:0]  a;
        logic [47:0] r;
        a = exp_active();
        if (a[ch] !== 1'b1)
            r = 48'h0;
        else if (un)
            r = {AICS_UNDER_15, 32'h0};
        else if (ov)
            r = {AICS_OVER_15, AICS_OVER_13, AICS_OVER_12};
        else
            r = {v, 16'(4096 + (v >>> 3)), 16'(2048 + (v >>> 4))};
        meas_q.push_back({3'(ch), r});
        @(negedge clk);
        meas_strobe = 1'b1;
        meas_chan = 3'(ch);
        meas_value = v;
        meas_under = un;
        meas_over = ov;
    endtask

    task automatic settle();
        u_aics_host_model.release_bus();
        meas_strobe = 1'b0;
        meas_value = ~meas_value;
        repeat (3) @(negedge clk);
    endtask

    always @(posedge clk)
        cmd_seen <= cmd_wr && channel_command != 16'h0000;

    always @(negedge clk)
    begin
        logic [48:0] n;
        logic [50:0] m;
        if (cmd_seen)
        begin
            n = cmd_q.pop_front();
            cmp_word("command_response", n[47:32], command_response);
            if (!n[48])
            begin
                cmp_word("response_word_one", n[31:16], response_word_one);
                cmp_word("response_word_two", n[15:0], response_word_two);
            end
        end
        if (result_valid === 1'b1)
        begin
            m = meas_q.pop_front();
            cmp_word("result_chan", {13'h0, m[50:48]}, {13'h0, result_chan});
            cmp_word("result_15", m[47:32], result_15);
            cmp_word("result_13", m[31:16], result_13);
            cmp_word("result_12", m[15:0], result_12);
        end
    end

    task automatic summarize();
        cmp_word("pending_notes", 16'h0000, 16'(cmd_q.size() + meas_q.size()));
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk);
        num_errors++;
        summarize();
    end

    initial
    begin
        logic [31:0] r;
        seed = 87;
        num_errors = 0;
        total_checks = 0;
        rstn = 1'b0;
        power_lost = 1'b0;
        meas_strobe = 1'b0;
        meas_chan = 3'h0;
        meas_value = 16'h0000;
        meas_under = 1'b0;
        meas_over = 1'b0;
        foreach (cfg[i])
            cfg[i] = 7'h00;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        cmp_word("command_response", 16'h0000, command_response);
        cmp_act(8'h00);
        do_cmd(0, 3, 1);
        do_cmd(0, 4, 28);
        do_cmd(1, 3, 4);
        do_cmd(0, 2, 33);
        do_cmd(0, 1, 5);
        do_cmd(0, 9, 5);
        do_cmd(0, 0, 5);
        foreach (temps[i])
            do_cmd(0, 7, i == 0 ? 29 : i == 1 ? 37 : i == 2 ? 63 : i == 3 ? 117 : 0);
        do_cmd(1, 7, 8);
        do_cmd(1, 1, 2);
        foreach (codes[i])
        begin
            do_cmd(0, 6, codes[i]);
            do_cmd(1, 5, 6);
        end
        do_cmd(0, 8, 64);
        do_cmd(1, 9, 0);
        settle();
        cmp_act(exp_active());
        foreach (temps[i])
            do_meas(7, 16'(temps[i]), 1'b0, 1'b0);
        do_meas(7, 16'h8000, 1'b1, 1'b1);
        do_meas(5, 16'h0000, 1'b0, 1'b0);
        do_meas(5, 16'h7d00, 1'b0, 1'b1);
        do_meas(4, 16'h1234, 1'b0, 1'b0);
        do_meas(0, 16'h0100, 1'b0, 1'b0);
        repeat (40)
        begin
            r = $random(seed);
            do_meas(r[2:0], 16'(-32000 + int'(r[31:16] % 16'd64767)), r[7:4] == 4'h0, r[11:8] == 4'h0);
        end
        settle();
        power_lost = 1'b1;
        repeat (6) @(negedge clk);
        cmp_word("command_response", 16'h0000, command_response);
        cmp_act(8'h00);
        power_lost = 1'b0;
        foreach (cfg[i])
            cfg[i] = 7'h00;
        repeat (3) @(negedge clk);
        do_meas(7, 16'h0200, 1'b0, 1'b0);
        settle();
        do_cmd(0, 4, 9);
        do_cmd(1, 4, 3);
        settle();
        do_meas(3, 16'h0200, 1'b0, 1'b0);
        settle();
        summarize();
    end
endmodule
